// *** logic/input_pin_remap_defines.vh ***
/*
  Constants of the input pin remap selector block: register byte
  addresses, field positions, reset values and pin lookup figures.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef INPUT_PIN_REMAP_DEFINES_VH
`define INPUT_PIN_REMAP_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define REMAP_38_ADDR    12'h098
`define REMAP_42_ADDR    12'h0A8
`define REMAP_43_ADDR    12'h0AC
`define REMAP_44_ADDR    12'h0B0
`define REMAP_45_ADDR    12'h0B4
`define REMAP_46_ADDR    12'h0B8
`define REMAP_47_ADDR    12'h0BC
`define ROUTED_LVL_ADDR  12'h0C0

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define SEL_LO_LSB       0
`define SEL_HI_LSB       8
`define SEL_RESET        8'h00
`define NUM_ROUTES       13

// ----------------------------------------------------------------
// Pin lookup
// ----------------------------------------------------------------
`define NUM_PINS         64
`define PIN_IDX_W        6
`define PIN_BASE_CODE    8'h01
`define INACTIVE_LEVEL   1'b0

`endif

// *** logic/pin_sync.v ***
/*
  Two flip-flop synchroniser for a group of device pin levels.
  Assumes each bit is an independent level from outside the clock.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter W = 64
) (
  input  wire         i_ref_clk,
  input  wire         i_rstn,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// *** logic/pin_code_lookup.v ***
/*
  Maps one 8-bit selector code to the level of one remappable pin.
  Assumes synchronised pin levels; codes outside the pin range give
  the fixed inactive level.
*/
`timescale 1ns/100ps
`include "input_pin_remap_defines.vh"
module pin_code_lookup #(
  parameter [7:0] PIN_BASE = `PIN_BASE_CODE,
  parameter       INACT    = `INACTIVE_LEVEL
) (
  input  wire [7:0]           i_sel,
  input  wire [`NUM_PINS-1:0] i_pins,
  output wire                 o_level
);
  wire [8:0] offset;
  wire       in_range;

  // Code to pin index, unmapped codes inactive
  assign offset   = {1'b0, i_sel} - {1'b0, PIN_BASE};
  assign in_range = (i_sel >= PIN_BASE) &&
                    (offset < `NUM_PINS);
  assign o_level  = in_range ? i_pins[offset[`PIN_IDX_W-1:0]]
                             : INACT;
endmodule

// *** logic/input_pin_remap_select.v ***
/*
  Input pin remap selector: thirteen 8-bit selectors in seven APB
  registers choose which remappable pin feeds each peripheral input.
  Assumes an APB master on i_ref_clk and pin levels that are
  asynchronous to it.
*/
`timescale 1ns/100ps
`include "input_pin_remap_defines.vh"
module input_pin_remap_select (
  input  wire                 i_ref_clk,
  input  wire                 i_rstn,
  input  wire                 i_psel,
  input  wire                 i_penable,
  input  wire                 i_pwrite,
  input  wire [11:0]          i_paddr,
  input  wire [31:0]          i_pwdata,
  input  wire [3:0]           i_pstrb,
  output wire [31:0]          o_prdata,
  output wire                 o_pready,
  output wire                 o_pslverr,
  input  wire [`NUM_PINS-1:0] i_remappable_pin,
  output wire                 o_pwm_ctl_in12,
  output wire                 o_pwm_ctl_in13,
  output wire                 o_pwm_ctl_in14,
  output wire                 o_pwm_ctl_in15,
  output wire                 o_pwm_ctl_in16,
  output wire                 o_pwm_ctl_in18,
  output wire                 o_sent_rx_a,
  output wire                 o_sent_rx_b,
  output wire                 o_logic_cell_in_a,
  output wire                 o_logic_cell_in_b,
  output wire                 o_logic_cell_in_c,
  output wire                 o_logic_cell_in_d,
  output wire                 o_converter_trigger
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [7:0] lane_update;
    input [7:0] old_val;
    input [7:0] new_val;
    input       write_en;
    begin
      lane_update = write_en ? new_val : old_val;
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [7:0]  pwm_ctl_in12_pin_sel_q;
  reg  [7:0]  pwm_ctl_in13_pin_sel_q;
  reg  [7:0]  pwm_ctl_in14_pin_sel_q;
  reg  [7:0]  pwm_ctl_in15_pin_sel_q;
  reg  [7:0]  pwm_ctl_in16_pin_sel_q;
  reg  [7:0]  pwm_ctl_in18_pin_sel_q;
  reg  [7:0]  sent_rx_a_pin_sel_q;
  reg  [7:0]  sent_rx_b_pin_sel_q;
  reg  [7:0]  logic_cell_in_a_pin_sel_q;
  reg  [7:0]  logic_cell_in_b_pin_sel_q;
  reg  [7:0]  logic_cell_in_c_pin_sel_q;
  reg  [7:0]  logic_cell_in_d_pin_sel_q;
  reg  [7:0]  converter_trigger_pin_sel_q;
  reg  [31:0] prdata_q;
  reg         slverr_q;
  reg  [`NUM_ROUTES-1:0] level_q;
  reg  [31:0] rd_data;
  reg         rd_hit;
  reg  [6:0]  wr_sel;
  wire        setup_phase;
  wire        wr_access;
  wire        wr_lo;
  wire        wr_hi;
  wire [`NUM_PINS-1:0] pin_sync_lvl;
  wire [`NUM_ROUTES*8-1:0] sel_bus;
  wire [`NUM_ROUTES-1:0]   level_d;

  // ----------------------------------------------------------------
  // APB phase decode
  // ----------------------------------------------------------------
  assign setup_phase = i_psel & ~i_penable;
  assign wr_access   = i_psel & i_penable & i_pwrite;
  assign wr_lo       = i_pstrb[0];
  assign wr_hi       = i_pstrb[1];

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  always @* begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    wr_sel  = 7'h00;
    if (i_paddr == `REMAP_38_ADDR) begin
      rd_data[15:0] = {8'h00, pwm_ctl_in18_pin_sel_q};
      wr_sel[0]     = 1'b1;
    end else if (i_paddr == `REMAP_42_ADDR) begin
      rd_data[15:0] = {pwm_ctl_in13_pin_sel_q,
                       pwm_ctl_in12_pin_sel_q};
      wr_sel[1]     = 1'b1;
    end else if (i_paddr == `REMAP_43_ADDR) begin
      rd_data[15:0] = {pwm_ctl_in15_pin_sel_q,
                       pwm_ctl_in14_pin_sel_q};
      wr_sel[2]     = 1'b1;
    end else if (i_paddr == `REMAP_44_ADDR) begin
      rd_data[15:0] = {sent_rx_a_pin_sel_q,
                       pwm_ctl_in16_pin_sel_q};
      wr_sel[3]     = 1'b1;
    end else if (i_paddr == `REMAP_45_ADDR) begin
      rd_data[15:0] = {logic_cell_in_a_pin_sel_q,
                       sent_rx_b_pin_sel_q};
      wr_sel[4]     = 1'b1;
    end else if (i_paddr == `REMAP_46_ADDR) begin
      rd_data[15:0] = {logic_cell_in_c_pin_sel_q,
                       logic_cell_in_b_pin_sel_q};
      wr_sel[5]     = 1'b1;
    end else if (i_paddr == `REMAP_47_ADDR) begin
      rd_data[15:0] = {converter_trigger_pin_sel_q,
                       logic_cell_in_d_pin_sel_q};
      wr_sel[6]     = 1'b1;
    end else if (i_paddr == `ROUTED_LVL_ADDR) begin
      rd_data[`NUM_ROUTES-1:0] = level_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data and error captured in the setup cycle
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q <= i_pwrite ? 32'h0000_0000 : rd_data;
      slverr_q <= ~rd_hit;
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = 1'b1;
  assign o_pslverr = slverr_q & i_psel & i_penable;

  // ----------------------------------------------------------------
  // Remap register 38
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwm_ctl_in18_pin_sel_q <= `SEL_RESET;
    end else begin
      pwm_ctl_in18_pin_sel_q <= lane_update(pwm_ctl_in18_pin_sel_q,
        i_pwdata[`SEL_LO_LSB+:8], wr_access & wr_sel[0] & wr_lo);
    end
  end

  // ----------------------------------------------------------------
  // Remap register 42
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwm_ctl_in12_pin_sel_q <= `SEL_RESET;
      pwm_ctl_in13_pin_sel_q <= `SEL_RESET;
    end else begin
      pwm_ctl_in12_pin_sel_q <= lane_update(pwm_ctl_in12_pin_sel_q,
        i_pwdata[`SEL_LO_LSB+:8], wr_access & wr_sel[1] & wr_lo);
      pwm_ctl_in13_pin_sel_q <= lane_update(pwm_ctl_in13_pin_sel_q,
        i_pwdata[`SEL_HI_LSB+:8], wr_access & wr_sel[1] & wr_hi);
    end
  end

  // ----------------------------------------------------------------
  // Remap register 43
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwm_ctl_in14_pin_sel_q <= `SEL_RESET;
      pwm_ctl_in15_pin_sel_q <= `SEL_RESET;
    end else begin
      pwm_ctl_in14_pin_sel_q <= lane_update(pwm_ctl_in14_pin_sel_q,
        i_pwdata[`SEL_LO_LSB+:8], wr_access & wr_sel[2] & wr_lo);
      pwm_ctl_in15_pin_sel_q <= lane_update(pwm_ctl_in15_pin_sel_q,
        i_pwdata[`SEL_HI_LSB+:8], wr_access & wr_sel[2] & wr_hi);
    end
  end

  // ----------------------------------------------------------------
  // Remap register 44
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwm_ctl_in16_pin_sel_q <= `SEL_RESET;
      sent_rx_a_pin_sel_q    <= `SEL_RESET;
    end else begin
      pwm_ctl_in16_pin_sel_q <= lane_update(pwm_ctl_in16_pin_sel_q,
        i_pwdata[`SEL_LO_LSB+:8], wr_access & wr_sel[3] & wr_lo);
      sent_rx_a_pin_sel_q <= lane_update(sent_rx_a_pin_sel_q,
        i_pwdata[`SEL_HI_LSB+:8], wr_access & wr_sel[3] & wr_hi);
    end
  end

  // ----------------------------------------------------------------
  // Remap register 45
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sent_rx_b_pin_sel_q       <= `SEL_RESET;
      logic_cell_in_a_pin_sel_q <= `SEL_RESET;
    end else begin
      sent_rx_b_pin_sel_q <= lane_update(sent_rx_b_pin_sel_q,
        i_pwdata[`SEL_LO_LSB+:8], wr_access & wr_sel[4] & wr_lo);
      logic_cell_in_a_pin_sel_q <= lane_update(
        logic_cell_in_a_pin_sel_q,
        i_pwdata[`SEL_HI_LSB+:8], wr_access & wr_sel[4] & wr_hi);
    end
  end

  // ----------------------------------------------------------------
  // Remap register 46
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      logic_cell_in_b_pin_sel_q <= `SEL_RESET;
      logic_cell_in_c_pin_sel_q <= `SEL_RESET;
    end else begin
      logic_cell_in_b_pin_sel_q <= lane_update(
        logic_cell_in_b_pin_sel_q,
        i_pwdata[`SEL_LO_LSB+:8], wr_access & wr_sel[5] & wr_lo);
      logic_cell_in_c_pin_sel_q <= lane_update(
        logic_cell_in_c_pin_sel_q,
        i_pwdata[`SEL_HI_LSB+:8], wr_access & wr_sel[5] & wr_hi);
    end
  end

  // ----------------------------------------------------------------
  // Remap register 47
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      logic_cell_in_d_pin_sel_q   <= `SEL_RESET;
      converter_trigger_pin_sel_q <= `SEL_RESET;
    end else begin
      logic_cell_in_d_pin_sel_q <= lane_update(
        logic_cell_in_d_pin_sel_q,
        i_pwdata[`SEL_LO_LSB+:8], wr_access & wr_sel[6] & wr_lo);
      converter_trigger_pin_sel_q <= lane_update(
        converter_trigger_pin_sel_q,
        i_pwdata[`SEL_HI_LSB+:8], wr_access & wr_sel[6] & wr_hi);
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  pin_sync #(
    .W (`NUM_PINS)
  ) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_remappable_pin),
    .o_sync    (pin_sync_lvl)
  );

  // ----------------------------------------------------------------
  // Selector bus, one byte per routed input
  // ----------------------------------------------------------------
  assign sel_bus = {converter_trigger_pin_sel_q,
                    logic_cell_in_d_pin_sel_q,
                    logic_cell_in_c_pin_sel_q,
                    logic_cell_in_b_pin_sel_q,
                    logic_cell_in_a_pin_sel_q,
                    sent_rx_b_pin_sel_q,
                    sent_rx_a_pin_sel_q,
                    pwm_ctl_in18_pin_sel_q,
                    pwm_ctl_in16_pin_sel_q,
                    pwm_ctl_in15_pin_sel_q,
                    pwm_ctl_in14_pin_sel_q,
                    pwm_ctl_in13_pin_sel_q,
                    pwm_ctl_in12_pin_sel_q};

  // ----------------------------------------------------------------
  // Code to pin lookups
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_ROUTES; g = g + 1) begin : g_route
      pin_code_lookup #(
        .PIN_BASE (`PIN_BASE_CODE),
        .INACT    (`INACTIVE_LEVEL)
      ) u_lookup (
        .i_sel   (sel_bus[g*8+:8]),
        .i_pins  (pin_sync_lvl),
        .o_level (level_d[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Routed levels to peripherals
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      level_q <= {`NUM_ROUTES{`INACTIVE_LEVEL}};
    end else begin
      level_q <= level_d;
    end
  end

  assign o_pwm_ctl_in12      = level_q[0];
  assign o_pwm_ctl_in13      = level_q[1];
  assign o_pwm_ctl_in14      = level_q[2];
  assign o_pwm_ctl_in15      = level_q[3];
  assign o_pwm_ctl_in16      = level_q[4];
  assign o_pwm_ctl_in18      = level_q[5];
  assign o_sent_rx_a         = level_q[6];
  assign o_sent_rx_b         = level_q[7];
  assign o_logic_cell_in_a   = level_q[8];
  assign o_logic_cell_in_b   = level_q[9];
  assign o_logic_cell_in_c   = level_q[10];
  assign o_logic_cell_in_d   = level_q[11];
  assign o_converter_trigger = level_q[12];

endmodule

// *** bench/pin_remap_chk_sva.sv ***
/* Checker for the input pin remap selector, at its top ports.
   Assumes zero-wait APB and a three-edge pin path. */
`timescale 1ns/100ps
`include "input_pin_remap_defines.vh"
module pin_remap_chk (
  input logic                 i_ref_clk,
  input logic                 i_rstn,
  input logic                 i_psel,
  input logic                 i_penable,
  input logic                 i_pwrite,
  input logic [11:0]          i_paddr,
  input logic [31:0]          i_pwdata,
  input logic [3:0]           i_pstrb,
  input logic [31:0]          o_prdata,
  input logic                 o_pready,
  input logic                 o_pslverr,
  input logic [`NUM_PINS-1:0] i_remappable_pin,
  input logic                 o_pwm_ctl_in12,
  input logic                 o_pwm_ctl_in13,
  input logic                 o_pwm_ctl_in14,
  input logic                 o_pwm_ctl_in15,
  input logic                 o_pwm_ctl_in16,
  input logic                 o_pwm_ctl_in18,
  input logic                 o_sent_rx_a,
  input logic                 o_sent_rx_b,
  input logic                 o_logic_cell_in_a,
  input logic                 o_logic_cell_in_b,
  input logic                 o_logic_cell_in_c,
  input logic                 o_logic_cell_in_d,
  input logic                 o_converter_trigger
);
  // ----------------------------------------------------------------
  // Shadow of the selectors and delayed pins
  // ----------------------------------------------------------------
  logic [15:0]  sh [0:6];
  logic [63:0]  p1, p2, p3;
  logic [3:0]   qs;
  logic [2:0]   ix;
  logic [12:0]  ev;
  wire  [103:0] sv = {sh[6], sh[5], sh[4], sh[3][15:8], sh[0][7:0],
                      sh[3][7:0], sh[2], sh[1]};
  wire  [12:0]  ov = {o_converter_trigger, o_logic_cell_in_d,
                      o_logic_cell_in_c, o_logic_cell_in_b,
                      o_logic_cell_in_a, o_sent_rx_b, o_sent_rx_a,
                      o_pwm_ctl_in18, o_pwm_ctl_in16, o_pwm_ctl_in15,
                      o_pwm_ctl_in14, o_pwm_ctl_in13, o_pwm_ctl_in12};
  wire acc    = i_psel && i_penable;
  wire rd     = acc && !i_pwrite;
  wire mapped = (ix != 3'h7) || (i_paddr == `ROUTED_LVL_ADDR);
  function automatic logic lk(input logic [7:0] c, input logic [63:0] p);
    lk = (c >= 8'h01 && c <= 8'h40) ? p[c[5:0] - 6'h01] : 1'b0;
  endfunction
  always_comb begin
    case (i_paddr)
      `REMAP_38_ADDR: ix = 3'h0;
      `REMAP_42_ADDR: ix = 3'h1;
      `REMAP_43_ADDR: ix = 3'h2;
      `REMAP_44_ADDR: ix = 3'h3;
      `REMAP_45_ADDR: ix = 3'h4;
      `REMAP_46_ADDR: ix = 3'h5;
      `REMAP_47_ADDR: ix = 3'h6;
      default:        ix = 3'h7;
    endcase
    for (int k = 0; k < 13; k++) ev[k] = lk(sv[8*k +: 8], p3);
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int k = 0; k < 7; k++) sh[k] <= 16'h0000;
      {p1, p2, p3} <= '0;
      qs <= 4'h0;
    end else begin
      p1 <= i_remappable_pin;
      p2 <= p1;
      p3 <= p2;
      qs <= (acc && i_pwrite) ? 4'h0 : qs + {3'h0, qs != 4'hF};
      if (acc && i_pwrite && ix != 3'h7) begin
        if (i_pstrb[0]) sh[ix][7:0] <= i_pwdata[7:0];
        if (i_pstrb[1] && ix != 3'h0) sh[ix][15:8] <= i_pwdata[15:8];
      end
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ready_always_a: assert property (o_pready)
    else $error("pready low");
  err_mapped_a: assert property (acc |-> o_pslverr == !mapped)
    else $error("pslverr wrong for address");
  err_idle_a: assert property (!acc |-> !o_pslverr)
    else $error("pslverr outside access");
  upper_zero_a: assert property (rd |-> o_prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  r38_hi_zero_a: assert property (
    rd && ix == 3'h0 |-> o_prdata[15:8] == 8'h00)
    else $error("reg 38 upper byte not zero");
  read_back_a: assert property (
    rd && ix != 3'h7 |-> o_prdata[15:0] == sh[ix])
    else $error("read data differs from written");
  pwm_route_a: assert property (
    qs >= 4'h4 |-> ov[5:0] == ev[5:0])
    else $error("pwm input level wrong");
  misc_route_a: assert property (
    qs >= 4'h4 |-> ov[12:6] == ev[12:6])
    else $error("sent, cell or trigger level wrong");
  cover property (acc && i_pwrite && ix != 3'h7);
  cover property (acc && o_pslverr);
  cover property (qs >= 4'h4 && ov != 13'h0000);
endmodule
bind input_pin_remap_select pin_remap_chk i_pin_remap_chk (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_remappable_pin(i_remappable_pin), .o_pwm_ctl_in12(o_pwm_ctl_in12),
  .o_pwm_ctl_in13(o_pwm_ctl_in13), .o_pwm_ctl_in14(o_pwm_ctl_in14),
  .o_pwm_ctl_in15(o_pwm_ctl_in15), .o_pwm_ctl_in16(o_pwm_ctl_in16),
  .o_pwm_ctl_in18(o_pwm_ctl_in18), .o_sent_rx_a(o_sent_rx_a),
  .o_sent_rx_b(o_sent_rx_b), .o_logic_cell_in_a(o_logic_cell_in_a),
  .o_logic_cell_in_b(o_logic_cell_in_b),
  .o_logic_cell_in_c(o_logic_cell_in_c),
  .o_logic_cell_in_d(o_logic_cell_in_d),
  .o_converter_trigger(o_converter_trigger));

// *** bench/pin_source.sv ***
/* Model of the device pins: holds a pattern or walks it round.
   Assumes the bench sets the pattern; pins are always driven. */
`timescale 1ns/100ps
module pin_source (
  input  logic        i_ref_clk,
  input  logic        i_rstn,
  input  logic [63:0] i_pattern,
  input  logic        i_walk,
  output logic [63:0] o_pins
);
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn)
      o_pins <= 64'h0;
    else if (i_walk)
      o_pins <= {o_pins[62:0], o_pins[63]};
    else
      o_pins <= i_pattern;
  end
endmodule

// *** bench/tb.sv ***
/* Self-checking bench of the input pin remap selector.
   Assumes the pin source model and the bound checker. */
`timescale 1ns/100ps
`include "input_pin_remap_defines.vh"
module tb;
  typedef struct {
    logic [11:0] addr;
    logic [31:0] wdat;
    logic [3:0]  strb;
    logic [31:0] rexp;
  } row_t;
  logic        clk, rstn, psel, penable, pwrite, walk, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr;
  logic [63:0] pins, pattern;
  wire  [12:0] ov;
  wire  [31:0] ovw = {19'h0, ov};
  logic [31:0] lv;
  row_t        rows [0:6];
  int          n_fail, num_checks;
  input_pin_remap_select i_input_pin_remap_select (
    .i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_remappable_pin(pins),
    .o_pwm_ctl_in12(ov[0]), .o_pwm_ctl_in13(ov[1]),
    .o_pwm_ctl_in14(ov[2]), .o_pwm_ctl_in15(ov[3]),
    .o_pwm_ctl_in16(ov[4]), .o_pwm_ctl_in18(ov[5]),
    .o_sent_rx_a(ov[6]), .o_sent_rx_b(ov[7]),
    .o_logic_cell_in_a(ov[8]), .o_logic_cell_in_b(ov[9]),
    .o_logic_cell_in_c(ov[10]), .o_logic_cell_in_d(ov[11]),
    .o_converter_trigger(ov[12]));
  pin_source i_pin_source (.i_ref_clk(clk), .i_rstn(rstn),
    .i_pattern(pattern), .i_walk(walk), .o_pins(pins));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb wait", n, 32'h1);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rstn, psel, penable, pwrite, walk} = 5'h00;
    {paddr, pwdata, pstrb, pattern} = '0;
    n_fail = 0;
    num_checks = 0;
    rows[0] = '{`REMAP_38_ADDR, 32'hFFFF5A40, 4'hF, 32'h00000040};
    rows[1] = '{`REMAP_42_ADDR, 32'hABCD0201, 4'hF, 32'h00000201};
    rows[2] = '{`REMAP_43_ADDR, 32'h00000403, 4'h3, 32'h00000403};
    rows[3] = '{`REMAP_44_ADDR, 32'h00000605, 4'h3, 32'h00000605};
    rows[4] = '{`REMAP_45_ADDR, 32'h00000807, 4'h3, 32'h00000807};
    rows[5] = '{`REMAP_46_ADDR, 32'h00000A09, 4'h3, 32'h00000A09};
    rows[6] = '{`REMAP_47_ADDR, 32'h00004100, 4'h3, 32'h00004100};
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].addr, rows[i].wdat, rows[i].strb);
      apb(1'b0, rows[i].addr, 32'h0, 4'h0);
      chk("readback", rd, rows[i].rexp);
    end
    $display("test register table done");
    for (int j = 0; j < 2; j++) begin
      pattern <= j ? ~64'h8000000000000155 : 64'h8000000000000155;
      lv = j ? 32'h0000054A : 32'h000002B5;
      repeat (5) @(posedge clk);
      chk("pwm", ovw & 32'h3F, lv & 32'h3F);
      chk("sent", ovw & 32'hC0, lv & 32'hC0);
      chk("cell", ovw & 32'h1F00, lv & 32'h1F00);
      apb(1'b0, `ROUTED_LVL_ADDR, 32'h0, 4'h0);
      chk("status", rd, lv);
    end
    walk <= 1'b1;
    repeat (70) @(posedge clk);
    walk <= 1'b0;
    apb(1'b1, `REMAP_47_ADDR, 32'h00004001, 4'h3);
    pattern <= 64'h8000000000000001;
    repeat (5) @(posedge clk);
    chk("trigger", ovw & 32'h1800, 32'h1800);
    $display("test routing done");
    apb(1'b1, `REMAP_42_ADDR, 32'hFFFF7700, 4'h2);
    apb(1'b1, `REMAP_42_ADDR, 32'hEEEEEEEE, 4'hC);
    apb(1'b0, `REMAP_42_ADDR, 32'h0, 4'h0);
    chk("byte lanes", rd, 32'h00007701);
    apb(1'b1, 12'h0A0, 32'h0000FFFF, 4'hF);
    chk("unmapped wr err", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h0A0, 32'h0, 4'h0);
    chk("unmapped rd", rd, 32'h0);
    apb(1'b1, `ROUTED_LVL_ADDR, 32'h0000FFFF, 4'hF);
    chk("status wr err", {31'h0, err}, 32'h0);
    $display("test bus edges done");
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    chk("outputs in reset", {19'h0, ov}, 32'h0);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 32'h0, 4'h0);
      chk("reset value", rd, 32'h0);
    end
    $display("test second reset done");
    report_and_stop;
  end
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end
endmodule
